// file: logic/vba_requester.sv
// Summary of operation
// - grant taken means bbsy low until release
// - master may finish before releasing on clear
// - same level ordered by daisy-chain position
// - wants-bus drives own request line low
// - pass grant on when not wanting bus
// - on grant: bbsy low, drop request, granted
// - release-when-done frees bbsy when wants drops
// - release-on-request frees bbsy only on others
// - bbsy held low at least 90 ns
// - bbsy low 30 ns after request released
// - bbsy released only after grant returns high
// - withdraw request only after bbsy low, within 50ns
`timescale 1ns/10ps
`default_nettype none

module vba_requester (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // configuration, changed only while idle
  input wire logic [1:0] req_level,
  input wire logic ror_mode,
  // board side handshake
  input wire logic wants_bus,
  output logic granted_bus,
  output logic bus_clear_seen,
  // backplane arbitration lines
  input wire vba_pkg::vba_bus_in_t bus_in,
  output vba_pkg::vba_bus_out_t bus_out
);

  // ==========================================================
  // synchronisers
  vba_pkg::vba_bus_in_t sync1_reg;
  vba_pkg::vba_bus_in_t sync2_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
    end else begin
      sync1_reg <= bus_in;
      sync2_reg <= sync1_reg;
    end
  end

  logic [3:0] br_s;
  logic [3:0] bg_s;
  logic bbsy_s;
  logic grant_seen;
  logic other_req;

  assign br_s = sync2_reg.br_n;
  assign bg_s = sync2_reg.bg_in_n;
  assign bbsy_s = sync2_reg.bbsy_n;
  assign grant_seen = !bg_s[req_level];
  // own request is released while owning, so any low line is another
  assign other_req = |(~br_s);

  // ==========================================================
  // state and hold counter
  vba_pkg::vba_state_t state_reg;
  vba_pkg::vba_state_t state_next;
  logic [vba_pkg::CNT_W-1:0] own_cnt_reg;
  logic hold_done;
  logic release_ok;

  // one counter covers both minimums: the request is dropped in the
  // same cycle that bbsy is driven, so both start together
  assign hold_done =
    (own_cnt_reg >= vba_pkg::CNT_W'(vba_pkg::BBSY_MIN_CYC)) &&
    (own_cnt_reg >= vba_pkg::CNT_W'(vba_pkg::BR_GAP_CYC));

  assign release_ok = hold_done && !grant_seen && !wants_bus &&
    (!ror_mode || other_req);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      vba_pkg::ST_IDLE: begin
        if (wants_bus) begin
          state_next = vba_pkg::ST_REQ;
        end
      end
      vba_pkg::ST_REQ: begin
        if (!wants_bus) begin
          // an ungranted request may only go once bbsy is seen low
          if (!bbsy_s) begin
            state_next = vba_pkg::ST_IDLE;
          end else begin
            state_next = vba_pkg::ST_WDRAW;
          end
        end else if (grant_seen) begin
          state_next = vba_pkg::ST_OWN;
        end
      end
      vba_pkg::ST_OWN: begin
        if (release_ok) begin
          state_next = vba_pkg::ST_IDLE;
        end
      end
      vba_pkg::ST_WDRAW: begin
        if (wants_bus) begin
          state_next = vba_pkg::ST_REQ;
        end else if (!bbsy_s) begin
          state_next = vba_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = vba_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= vba_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      own_cnt_reg <= vba_pkg::CNT_RESET;
    end else if (state_reg != vba_pkg::ST_OWN) begin
      own_cnt_reg <= vba_pkg::CNT_RESET;
    end else if (!(&own_cnt_reg)) begin
      own_cnt_reg <= own_cnt_reg + vba_pkg::CNT_W'(1);
    end
  end

  // ==========================================================
  // pin drivers, registered from the next state
  logic br_on_reg;
  logic bbsy_on_reg;
  logic granted_reg;
  logic bclr_reg;
  logic [3:0] bg_out_reg;
  logic passing;

  // the own level's grant is blocked while requesting or owning
  assign passing = (state_next == vba_pkg::ST_IDLE) ||
    (state_next == vba_pkg::ST_WDRAW);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      br_on_reg <= 1'b0;
    end else begin
      br_on_reg <= (state_next == vba_pkg::ST_REQ) ||
        (state_next == vba_pkg::ST_WDRAW);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bbsy_on_reg <= 1'b0;
      granted_reg <= 1'b0;
    end else begin
      bbsy_on_reg <= (state_next == vba_pkg::ST_OWN);
      granted_reg <= (state_next == vba_pkg::ST_OWN);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bg_out_reg <= 4'hf;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (i == int'(req_level)) begin
          bg_out_reg[i] <= passing ? bg_s[i] : 1'b1;
        end else begin
          bg_out_reg[i] <= bg_s[i];
        end
      end
    end
  end

  // clear is only reported; the master chooses when to let go
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bclr_reg <= 1'b0;
    end else begin
      bclr_reg <= !sync2_reg.bclr_n;
    end
  end

  always_comb begin
    bus_out.br_out = 4'h0;
    bus_out.br_oe_n = 4'hf;
    bus_out.br_oe_n[req_level] = !br_on_reg;
    bus_out.bbsy_out = 1'b0;
    bus_out.bbsy_oe_n = !bbsy_on_reg;
    bus_out.bg_out_n = bg_out_reg;
  end

  assign granted_bus = granted_reg;
  assign bus_clear_seen = bclr_reg;

  // ==========================================================
  // assertions
  sequence s_bbsy_taken;
    $rose(bbsy_on_reg);
  endsequence

  sequence s_bbsy_dropped;
    $fell(bbsy_on_reg);
  endsequence

  // the hold counter runs from the cycle bbsy is taken, so a count
  // check at release stands in for a long repetition
  a_bbsy_min_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_bbsy_dropped |->
      $past(own_cnt_reg) >= vba_pkg::CNT_W'(vba_pkg::BBSY_MIN_CYC))
    else $error("bbsy released before minimum hold");

  a_br_gap_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(br_on_reg) && bbsy_on_reg |-> bbsy_on_reg[*3])
    else $error("bbsy released too soon after request");

  a_grant_before_own: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_bbsy_taken |-> $past(grant_seen) && !br_on_reg && granted_bus)
    else $error("bbsy driven without grant or request kept");

  a_release_grant_high: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(bbsy_on_reg) |-> $past(!grant_seen) && $past(!wants_bus))
    else $error("bbsy released while grant low or bus wanted");

  a_request_on_want: assert property (
    @(posedge clk) disable iff (!rst_n)
    state_reg == vba_pkg::ST_IDLE && wants_bus |=> br_on_reg)
    else $error("wanted bus but request not driven");

  a_grant_pass_on: assert property (
    @(posedge clk) disable iff (!rst_n)
    state_reg == vba_pkg::ST_IDLE && !wants_bus && grant_seen
    |=> !bus_out.bg_out_n[$past(req_level)])
    else $error("unused grant not passed on");

  a_rwd_release: assert property (
    @(posedge clk) disable iff (!rst_n)
    state_reg == vba_pkg::ST_OWN && !ror_mode && !wants_bus &&
    hold_done && !grant_seen |=> !bbsy_on_reg)
    else $error("release-when-done kept bbsy");

  a_ror_parking: assert property (
    @(posedge clk) disable iff (!rst_n)
    state_reg == vba_pkg::ST_OWN && ror_mode && !other_req
    |=> bbsy_on_reg)
    else $error("release-on-request let go with no other request");

  a_withdraw_timing: assert property (
    @(posedge clk) disable iff (!rst_n)
    state_reg == vba_pkg::ST_WDRAW && !wants_bus && !bbsy_s
    |=> !br_on_reg)
    else $error("withdrawal not done after bbsy low");

  a_withdraw_wait: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(br_on_reg) && !bbsy_on_reg |-> $past(!bbsy_s))
    else $error("request withdrawn while bbsy high");

endmodule

`default_nettype wire

// file: logic/vba_pkg.sv
package vba_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BBSY_MIN_NS = 90;
  localparam int BR_GAP_NS = 30;
  localparam int WITHDRAW_MAX_NS = 50;
  // least times round up to whole cycles
  localparam int BBSY_MIN_CYC = (BBSY_MIN_NS + CLK_PERIOD_NS - 1) /
    CLK_PERIOD_NS;
  localparam int BR_GAP_CYC = (BR_GAP_NS + CLK_PERIOD_NS - 1) /
    CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;

  // ==========================================================
  // requester states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_REQ = 4'b0010,
    ST_OWN = 4'b0100,
    ST_WDRAW = 4'b1000
  } vba_state_t;

  // ==========================================================
  // backplane lines as seen and as driven (all active low on the wire)
  typedef struct packed {
    logic [3:0] br_n;
    logic [3:0] bg_in_n;
    logic bbsy_n;
    logic bclr_n;
  } vba_bus_in_t;

  typedef struct packed {
    logic [3:0] br_out;
    logic [3:0] br_oe_n;
    logic bbsy_out;
    logic bbsy_oe_n;
    logic [3:0] bg_out_n;
  } vba_bus_out_t;

endpackage

// file: dv/vba_arb_model.sv
`timescale 1ns/10ps
`default_nettype none

module vba_arb_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // extra cycles before a grant, for slow answers
  input wire logic [3:0] dly,
  // backplane lines
  input wire logic [3:0] br_n,
  input wire logic bbsy_n,
  output logic [3:0] bg_n,
  output logic bclr_n
);
  // ==========================================================
  // prioritized slot-one arbiter
  logic [1:0] lvl_reg;
  logic [1:0] top;
  logic gnt_on;
  logic busy_seen;
  logic [3:0] wait_cnt;

  assign top = !br_n[3] ? 2'h3 : !br_n[2] ? 2'h2 :
    !br_n[1] ? 2'h1 : 2'h0;
  assign bclr_n = !(gnt_on &&
    ((~br_n) >> ({1'b0, lvl_reg} + 3'h1)) != 4'h0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bg_n <= 4'hf;
      lvl_reg <= 2'h0;
      gnt_on <= 1'b0;
      busy_seen <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (!gnt_on) begin
      // levels are read at grant time, so a withdrawn request is never won
      if (bbsy_n && br_n != 4'hf) begin
        wait_cnt <= wait_cnt + 4'h1;
        if (wait_cnt >= dly) begin
          bg_n <= ~(4'h1 << top);
          lvl_reg <= top;
          gnt_on <= 1'b1;
          wait_cnt <= 4'h0;
        end
      end else begin
        wait_cnt <= 4'h0;
      end
    end else if (!bbsy_n) begin
      bg_n <= 4'hf;
      busy_seen <= 1'b1;
    end else if (busy_seen) begin
      gnt_on <= 1'b0;
      busy_seen <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// file: dv/test_vba_requester.sv
`timescale 1ns/10ps
`default_nettype none

module test_vba_requester;
  logic clk;
  logic rst_n;
  logic ror_mode;
  logic wants_bus;
  logic oth_bbsy_n;
  logic granted_bus;
  logic bus_clear_seen;
  logic bclr_n;
  logic [1:0] req_level;
  logic [3:0] oth_br_n;
  logic [3:0] dly;
  logic [3:0] bg_n;
  vba_pkg::vba_bus_in_t bus_in;
  vba_pkg::vba_bus_out_t bus_out;
  int miscompares;
  int tests_run;
  int cycles;
  int i;

  // open-drain lines: low if anyone pulls
  assign bus_in = '{br_n: oth_br_n & bus_out.br_oe_n, bg_in_n: bg_n,
    bbsy_n: oth_bbsy_n & bus_out.bbsy_oe_n, bclr_n: bclr_n};

  vba_requester dut (.clk(clk), .rst_n(rst_n), .req_level(req_level),
    .ror_mode(ror_mode), .wants_bus(wants_bus), .granted_bus(granted_bus),
    .bus_clear_seen(bus_clear_seen), .bus_in(bus_in), .bus_out(bus_out));
  vba_arb_model arb (.clk(clk), .rst_n(rst_n), .dly(dly),
    .br_n(bus_in.br_n), .bbsy_n(bus_in.bbsy_n), .bg_n(bg_n), .bclr_n(bclr_n));

  // ==========================================================
  // helpers
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task chk(input string name, input logic [3:0] exp, input logic [3:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task results;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // bench plays a downstream requester on level l
  task other_take(input int l);
    for (i = 0; i < 40 && bus_out.bg_out_n[l] !== 1'b0; i++) cyc(1);
    chk("bg_out_n", 4'h0, {3'h0, bus_out.bg_out_n[l]});
    oth_bbsy_n = 1'b0;
    oth_br_n[l] = 1'b1;
    for (i = 0; i < 40 && bus_out.bg_out_n[l] !== 1'b1; i++) cyc(1);
    cyc(9);
    oth_bbsy_n = 1'b1;
    cyc(3);
  endtask

  // ==========================================================
  // scenarios
  task test_own;
    req_level = 2'h2;
    wants_bus = 1'b1;
    cyc(2);
    chk("br_oe_n", 4'hb, bus_out.br_oe_n);
    for (i = 0; i < 40 && granted_bus !== 1'b1; i++) cyc(1);
    chk("bbsy_oe_n", 4'h0, {3'h0, bus_out.bbsy_oe_n});
    chk("br_oe_n", 4'hf, bus_out.br_oe_n);
    chk("br_out", 4'h0, bus_out.br_out);
    chk("bbsy_out", 4'h0, {3'h0, bus_out.bbsy_out});
    wants_bus = 1'b0;
    cyc(7);
    chk("bbsy_oe_n", 4'h0, {3'h0, bus_out.bbsy_oe_n});
    cyc(10);
    chk("bbsy_oe_n", 4'h1, {3'h0, bus_out.bbsy_oe_n});
    chk("granted_bus", 4'h0, {3'h0, granted_bus});
    $display("test_own done");
  endtask

  task test_withdraw;
    req_level = 2'h0;
    oth_bbsy_n = 1'b0;
    wants_bus = 1'b1;
    cyc(3);
    chk("br_oe_n", 4'he, bus_out.br_oe_n);
    wants_bus = 1'b0;
    cyc(5);
    chk("br_oe_n", 4'hf, bus_out.br_oe_n);
    oth_bbsy_n = 1'b1;
    cyc(3);
    $display("test_withdraw done");
  endtask

  task test_ror;
    req_level = 2'h1;
    ror_mode = 1'b1;
    dly = 4'h4;
    wants_bus = 1'b1;
    for (i = 0; i < 40 && granted_bus !== 1'b1; i++) cyc(1);
    wants_bus = 1'b0;
    cyc(20);
    chk("bbsy_oe_n", 4'h0, {3'h0, bus_out.bbsy_oe_n});
    chk("bus_clear_seen", 4'h0, {3'h0, bus_clear_seen});
    oth_br_n[3] = 1'b0;
    cyc(6);
    chk("bus_clear_seen", 4'h1, {3'h0, bus_clear_seen});
    cyc(6);
    chk("bbsy_oe_n", 4'h1, {3'h0, bus_out.bbsy_oe_n});
    other_take(3);
    ror_mode = 1'b0;
    dly = 4'h0;
    $display("test_ror done");
  endtask

  // ==========================================================
  // run
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // a hang costs a mismatch, then the normal report
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      results;
    end
  end

  initial begin
    rst_n = 1'b0;
    ror_mode = 1'b0;
    wants_bus = 1'b0;
    oth_bbsy_n = 1'b1;
    req_level = 2'h0;
    oth_br_n = 4'hf;
    dly = 4'h0;
    cyc(2);
    chk("br_oe_n", 4'hf, bus_out.br_oe_n);
    chk("bg_out_n", 4'hf, bus_out.bg_out_n);
    rst_n = 1'b1;
    cyc(2);
    test_own;
    test_withdraw;
    test_ror;
    results;
  end
endmodule

`default_nettype wire
